/* File: hdl/scc_top.sv */
// skip cycle on/off switch control with jittered oscillator and limit selection
// Operation
// - free running oscillator averaging 132 kHz
// - cycle start pulse and max duty window
// - 8 kHz peak-to-peak jitter swept at 1 kHz
// - enable low when pin pull exceeds 240 uA
// - sample enable once at cycle start
// - enabled sample turns switch on
// - disabled sample skips whole cycle
// - later enable changes ignored until next cycle
// - limit state machine follows enable history
// - no line resistor disables line undervoltage
// - off at current limit or window end
// - full limit high load, reduced medium load, lowest limit light load
`include "scc_consts.svh"

module scc_top #(
    parameter int JIT_HALF_CYC = `SCC_JIT_HALF_CYC,
    parameter int DMAX_PCT     = `SCC_DMAX_PCT
) (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       fb_pull_over_i,
    input  wire logic       ilim_reached_i,
    input  wire logic       line_res_absent_i,
    output logic            cycle_start_o,
    output logic            max_duty_window_o,
    output logic            switch_on_o,
    output logic            enable_sample_o,
    output logic [1:0]      ilim_sel_o,
    output logic            line_uv_en_o
);

    localparam int PER_MIN  = `SCC_PER_MIN;
    localparam int PER_MAX  = `SCC_PER_MAX;
    localparam int STEP_CYC = JIT_HALF_CYC / (PER_MAX - PER_MIN);

    if (JIT_HALF_CYC < (PER_MAX - PER_MIN) || JIT_HALF_CYC >= 131072) begin : g_chk_jit
        $error("jitter half period out of range");
    end
    if (DMAX_PCT < 1 || DMAX_PCT > 100) begin : g_chk_dmax
        $error("max duty percent out of range");
    end

    scc_pkg::scc_state_t s_q;
    scc_pkg::scc_state_t s_d;

    logic        en_lvl;
    logic        wrap;
    logic [7:0]  hist_nx;
    logic [3:0]  ones;
    logic [10:0] dmax_lim;
    logic [31:0] dmax_prod;

    always_comb begin
        s_d = s_q;
        // pin inputs pass two flops
        s_d.over_s1  = fb_pull_over_i;
        s_d.over_s2  = s_q.over_s1;
        s_d.lim_s1   = ilim_reached_i;
        s_d.lim_s2   = s_q.lim_s1;
        s_d.nores_s1 = line_res_absent_i;
        s_d.nores_s2 = s_q.nores_s1;

        en_lvl = !s_q.over_s2;

        // triangle sweep of the period
        if (s_q.mod_cnt >= 17'(JIT_HALF_CYC - 1)) begin
            s_d.mod_cnt = '0;
            s_d.dir_up  = !s_q.dir_up;
        end else begin
            s_d.mod_cnt = s_q.mod_cnt + 17'h00001;
        end
        if (s_q.step_cnt >= 11'(STEP_CYC - 1)) begin
            s_d.step_cnt = '0;
            if (s_q.dir_up && s_q.per < 11'(PER_MAX)) begin
                s_d.per = s_q.per + 11'h001;
            end else if (!s_q.dir_up && s_q.per > 11'(PER_MIN)) begin
                s_d.per = s_q.per - 11'h001;
            end
        end else begin
            s_d.step_cnt = s_q.step_cnt + 11'h001;
        end

        // cycle counter
        wrap = (s_q.cnt >= s_q.per - 11'h001);
        s_d.cnt   = wrap ? 11'h000 : s_q.cnt + 11'h001;
        s_d.start = wrap;
        dmax_prod = 32'(s_q.per) * 32'(DMAX_PCT) / 32'd100;
        dmax_lim  = dmax_prod[10:0];
        s_d.win   = (s_d.cnt < dmax_lim);

        // enable history and level choice
        hist_nx = {s_q.hist[6:0], en_lvl};
        ones    = 4'($countones(hist_nx));
        if (wrap) begin
            s_d.en_smp = en_lvl;
            s_d.hist   = hist_nx;
            if (ones >= 4'(`SCC_FULL_MIN_ONES)) begin
                s_d.lvl = scc_pkg::SCC_LIM_FULL;
            end else if (ones >= 4'(`SCC_RED_MIN_ONES)) begin
                s_d.lvl = scc_pkg::SCC_LIM_RED;
            end else begin
                s_d.lvl = scc_pkg::SCC_LIM_LOW;
            end
        end

        // switch: on only at cycle start, off by limit or window
        if (wrap) begin
            s_d.on = en_lvl;
        end else begin
            s_d.on = s_q.on && !s_q.lim_s2 && s_d.win;
        end

        s_d.uv_en = !s_q.nores_s2;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            s_q          <= '0;
            s_q.per      <= 11'(PER_MIN);
            s_q.dir_up   <= 1'b1;
            s_q.hist     <= 8'hFF;
            s_q.lvl      <= scc_pkg::SCC_LIM_FULL;
            s_q.uv_en    <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign cycle_start_o     = s_q.start;
    assign max_duty_window_o = s_q.win;
    assign switch_on_o       = s_q.on;
    assign enable_sample_o   = s_q.en_smp;
    assign ilim_sel_o        = s_q.lvl;
    assign line_uv_en_o      = s_q.uv_en;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_per_range;
        s_q.per >= 11'(PER_MIN) && s_q.per <= 11'(PER_MAX);
    endproperty
    a_per_range: assert property (p_per_range)
        else $error("period left jitter range");

    property p_start_win;
        s_q.start |-> s_q.win && s_q.cnt == 11'h000;
    endproperty
    a_start_win: assert property (p_start_win)
        else $error("cycle start without open duty window");

    property p_per_step;
        !$past(!rst_n_i) |-> (s_q.per == $past(s_q.per)) ||
            (s_q.per == $past(s_q.per) + 11'h001) || (s_q.per == $past(s_q.per) - 11'h001);
    endproperty
    a_per_step: assert property (p_per_step)
        else $error("period jumped more than one step");

    property p_sample;
        s_q.start |-> s_q.on == !$past(s_q.over_s2);
    endproperty
    a_sample: assert property (p_sample)
        else $error("switch state disagrees with enable sample");

    property p_en_on;
        s_q.start && s_q.en_smp |-> s_q.on;
    endproperty
    a_en_on: assert property (p_en_on)
        else $error("enabled cycle did not turn on");

    property p_no_late_on;
        s_q.on && !s_q.start |-> $past(s_q.on);
    endproperty
    a_no_late_on: assert property (p_no_late_on)
        else $error("switch turned on mid cycle");

    property p_off_cause;
        $fell(s_q.on) |-> $past(s_q.lim_s2) || !s_q.win || s_q.start;
    endproperty
    a_off_cause: assert property (p_off_cause)
        else $error("pulse ended without limit or window end");

    property p_win_bound;
        !s_q.win |-> !s_q.on;
    endproperty
    a_win_bound: assert property (p_win_bound)
        else $error("switch on outside duty window");

    property p_lvl_edge;
        s_q.lvl != $past(s_q.lvl) |-> s_q.start;
    endproperty
    a_lvl_edge: assert property (p_lvl_edge)
        else $error("limit level changed mid cycle");

    property p_full;
        s_q.start && $countones(s_q.hist) >= `SCC_FULL_MIN_ONES
            |-> s_q.lvl == scc_pkg::SCC_LIM_FULL;
    endproperty
    a_full: assert property (p_full)
        else $error("heavy load did not select full limit");

    property p_low;
        s_q.start && s_q.hist == 8'h00 |-> s_q.lvl == scc_pkg::SCC_LIM_LOW;
    endproperty
    a_low: assert property (p_low)
        else $error("idle history did not select lowest limit");

    property p_uv;
        !$past(!rst_n_i) |-> s_q.uv_en == !$past(s_q.nores_s2);
    endproperty
    a_uv: assert property (p_uv)
        else $error("line undervoltage enable wrong");

    property p_cyc_len;
        s_q.start |=> !s_q.start [*8];
    endproperty
    a_cyc_len: assert property (p_cyc_len)
        else $error("cycle starts too close together");

    property p_smp_hold;
        !s_q.start |-> $stable(s_q.en_smp);
    endproperty
    a_smp_hold: assert property (p_smp_hold)
        else $error("enable sample changed mid cycle");

    property p_smp_src;
        s_q.start |-> s_q.en_smp == !$past(s_q.over_s2);
    endproperty
    a_smp_src: assert property (p_smp_src)
        else $error("enable sample not taken at cycle start");

    property p_skip_off;
        !s_q.en_smp |-> !s_q.on;
    endproperty
    a_skip_off: assert property (p_skip_off)
        else $error("switch on in a skipped cycle");

    property p_lim_off;
        s_q.lim_s2 |=> !s_q.on || s_q.start;
    endproperty
    a_lim_off: assert property (p_lim_off)
        else $error("switch stayed on past current limit");

    property p_red;
        s_q.start && $countones(s_q.hist) >= `SCC_RED_MIN_ONES &&
            $countones(s_q.hist) < `SCC_FULL_MIN_ONES |-> s_q.lvl == scc_pkg::SCC_LIM_RED;
    endproperty
    a_red: assert property (p_red)
        else $error("medium load did not select reduced limit");

    property p_hist_new;
        s_q.start |-> s_q.hist[0] == s_q.en_smp;
    endproperty
    a_hist_new: assert property (p_hist_new)
        else $error("history did not take the new sample");

    property p_hist_hold;
        !s_q.start |-> $stable(s_q.hist);
    endproperty
    a_hist_hold: assert property (p_hist_hold)
        else $error("history changed mid cycle");

    property p_cnt_bound;
        s_q.cnt <= s_q.per;
    endproperty
    a_cnt_bound: assert property (p_cnt_bound)
        else $error("cycle counter ran past the period");

    property p_mod_bound;
        s_q.mod_cnt < 17'(JIT_HALF_CYC);
    endproperty
    a_mod_bound: assert property (p_mod_bound)
        else $error("sweep counter ran past half period");

    property p_sync_fb;
        !$past(!rst_n_i) |-> s_q.over_s2 == $past(s_q.over_s1);
    endproperty
    a_sync_fb: assert property (p_sync_fb)
        else $error("feedback synchroniser skipped a stage");

    property p_sync_lim;
        !$past(!rst_n_i) |-> s_q.lim_s2 == $past(s_q.lim_s1);
    endproperty
    a_sync_lim: assert property (p_sync_lim)
        else $error("limit synchroniser skipped a stage");

    property p_low_only;
        s_q.start && $countones(s_q.hist) < `SCC_RED_MIN_ONES
            |-> s_q.lvl == scc_pkg::SCC_LIM_LOW;
    endproperty
    a_low_only: assert property (p_low_only)
        else $error("light load did not select lowest limit");

    c_skip:   cover property (s_q.start && !s_q.on);
    c_limoff: cover property (s_q.lim_s2 && s_q.on ##1 !s_q.on);
    c_red:    cover property (s_q.lvl == scc_pkg::SCC_LIM_RED);
    c_low:    cover property (s_q.lvl == scc_pkg::SCC_LIM_LOW);
    c_wcut:   cover property ($fell(s_q.win) && $past(s_q.on));

endmodule : scc_top

/* File: hdl/scc_consts.svh */
// timing and level constants for the skip cycle switch control
`ifndef SCC_CONSTS_SVH
`define SCC_CONSTS_SVH
`define SCC_CLK_KHZ        200000
`define SCC_OSC_KHZ        132
`define SCC_JIT_PP_KHZ     8
`define SCC_JIT_RATE_KHZ   1
`define SCC_PER_NOM        (`SCC_CLK_KHZ / `SCC_OSC_KHZ)
`define SCC_PER_MIN        (`SCC_CLK_KHZ / (`SCC_OSC_KHZ + `SCC_JIT_PP_KHZ / 2))
`define SCC_PER_MAX        (`SCC_CLK_KHZ / (`SCC_OSC_KHZ - `SCC_JIT_PP_KHZ / 2))
`define SCC_JIT_HALF_CYC   (`SCC_CLK_KHZ / (2 * `SCC_JIT_RATE_KHZ))
`define SCC_DMAX_PCT       65
`define SCC_HIST_LEN       8
`define SCC_FULL_MIN_ONES  6
`define SCC_RED_MIN_ONES   3
`endif

/* File: hdl/scc_pkg.sv */
// types for the skip cycle switch control
package scc_pkg;
    typedef enum logic [1:0] {
        SCC_LIM_LOW,
        SCC_LIM_RED,
        SCC_LIM_FULL
    } scc_lim_t;

    typedef struct packed {
        logic       over_s1;
        logic       over_s2;
        logic       lim_s1;
        logic       lim_s2;
        logic       nores_s1;
        logic       nores_s2;
        logic [10:0] cnt;
        logic [10:0] per;
        logic [16:0] mod_cnt;
        logic [10:0] step_cnt;
        logic       dir_up;
        logic       start;
        logic       win;
        logic       on;
        logic       en_smp;
        logic [7:0] hist;
        scc_lim_t   lvl;
        logic       uv_en;
    } scc_state_t;
endpackage : scc_pkg

/* File: testbench/scc_opto_model.sv */
// optocoupler feedback model driving the pull-over level of the feedback sense pin
module scc_opto_model (
    input  wire logic sys_clk_i,
    input  wire logic out_high_i,
    output logic      fb_pull_over_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // led conducts while the output sits above regulation; one clock of coupling delay
    always @(posedge sys_clk_i) begin
        fb_pull_over_o <= out_high_i;
    end
endmodule : scc_opto_model

/* File: testbench/test_skip_cycle_switch_control.sv */
// self-checking bench for the skip cycle switch control
`include "scc_consts.svh"
module test_skip_cycle_switch_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sys_clk_i         = 1'b0;
    logic       rst_n_i           = 1'b0;
    logic       out_high          = 1'b0;
    logic       ilim_reached_i    = 1'b0;
    logic       line_res_absent_i = 1'b0;
    logic       fb_pull_over;
    logic       cycle_start_o;
    logic       max_duty_window_o;
    logic       switch_on_o;
    logic       enable_sample_o;
    logic       line_uv_en_o;
    logic [1:0] ilim_sel_o;
    logic [7:0] hist              = 8'hFF;
    logic [7:0] cur_sel           = 8'h02;
    logic       cur_on            = 1'b0;
    bit         first             = 1'b1;
    int         cur_lim           = 0;
    int         pmin              = 9999;
    int         pmax              = 0;
    int         n_mismatch        = 0;
    int         compares          = 0;

    localparam int WIN_MIN = `SCC_PER_MIN * `SCC_DMAX_PCT / 100;
    localparam int WIN_MAX = `SCC_PER_MAX * `SCC_DMAX_PCT / 100;

    always #2.5 sys_clk_i = ~sys_clk_i;

    scc_opto_model opto (
        .sys_clk_i     (sys_clk_i),
        .out_high_i    (out_high),
        .fb_pull_over_o(fb_pull_over)
    );

    scc_top #(.JIT_HALF_CYC(2000)) dut (
        .sys_clk_i        (sys_clk_i),
        .rst_n_i          (rst_n_i),
        .fb_pull_over_i   (fb_pull_over),
        .ilim_reached_i   (ilim_reached_i),
        .line_res_absent_i(line_res_absent_i),
        .cycle_start_o    (cycle_start_o),
        .max_duty_window_o(max_duty_window_o),
        .switch_on_o      (switch_on_o),
        .enable_sample_o  (enable_sample_o),
        .ilim_sel_o       (ilim_sel_o),
        .line_uv_en_o     (line_uv_en_o)
    );

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk

    task automatic results();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    // reset values, then line resistor sense both ways
    task automatic t_reset_line();
        repeat (3) @(posedge sys_clk_i);
        #1;
        chk(8'(switch_on_o), 8'h00);
        chk(8'(ilim_sel_o), 8'h02);
        chk(8'(line_uv_en_o), 8'h01);
        chk(8'(cycle_start_o), 8'h00);
        chk(8'(max_duty_window_o), 8'h00);
        chk(8'(enable_sample_o), 8'h00);
        @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        line_res_absent_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        #1;
        chk(8'(line_uv_en_o), 8'h00);
        @(posedge sys_clk_i);
        line_res_absent_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        #1;
        chk(8'(line_uv_en_o), 8'h01);
    endtask : t_reset_line

    // feedback for the next start changes one clock after this start; the running cycle is judged edge by
    // edge, then the new start; lim raises the switch current limit that many edges in
    task automatic cyc(input logic en, input int lim);
        int   n;
        int   wlow;
        logic exp_sw;
        n = 1;
        wlow = 0;
        @(posedge sys_clk_i);
        out_high <= ~en;
        #1;
        chk(8'(cycle_start_o), 8'h00);
        while (n < 2000) begin
            @(posedge sys_clk_i);
            n++;
            if (cur_lim > 0 && n == cur_lim) ilim_reached_i <= 1'b1;
            if (n == cur_lim + 10) ilim_reached_i <= 1'b0;
            #1;
            if (cycle_start_o === 1'b1) break;
            if (wlow > 0) chk(8'(max_duty_window_o), 8'h00);
            if (wlow == 0 && max_duty_window_o !== 1'b1) wlow = n;
            exp_sw = cur_on && max_duty_window_o === 1'b1 && !(cur_lim > 0 && n >= cur_lim + 3);
            chk(8'(switch_on_o), 8'(exp_sw));
            chk(8'(ilim_sel_o), cur_sel);
        end
        chk(8'(cycle_start_o), 8'h01);
        if (!first) begin
            chk(8'(n >= `SCC_PER_MIN && n <= `SCC_PER_MAX), 8'h01);
            chk(8'(wlow >= WIN_MIN && wlow <= WIN_MAX), 8'h01);
            pmin = (n < pmin) ? n : pmin;
            pmax = (n > pmax) ? n : pmax;
        end
        first = 1'b0;
        hist = {hist[6:0], en};
        cur_sel = ($countones(hist) >= `SCC_FULL_MIN_ONES) ? 8'h02 :
                  ($countones(hist) >= `SCC_RED_MIN_ONES) ? 8'h01 : 8'h00;
        chk(8'(switch_on_o), 8'(en));
        chk(8'(enable_sample_o), 8'(en));
        chk(8'(max_duty_window_o), 8'h01);
        chk(8'(ilim_sel_o), cur_sel);
        cur_on = en;
        cur_lim = lim;
    endtask : cyc

    initial begin
        t_reset_line();
        cyc(1'b1, 0);
        cyc(1'b1, 200);
        repeat (6) cyc(1'b0, 0);
        repeat (7) cyc(1'b1, 0);
        chk(8'(pmax > pmin), 8'h01);
        results();
    end

    // watchdog sized for about fifteen switching cycles plus margin
    initial begin
        repeat (40000) @(posedge sys_clk_i);
        n_mismatch++;
        results();
    end
endmodule : test_skip_cycle_switch_control
